// [logic/vpwl_pkg.sv]
// Purpose: Constants and types for the VPW link status and data block
// Assumes: 25 MHz system clock, AHB-Lite register access
// Notes: Symbol times are parameters with plain defaults
package vpwl_pkg;
	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [7:0] VPWL_IDX_STATUS = 8'hf0;
	localparam logic [7:0] VPWL_IDX_TXBYTE = 8'hf1;
	localparam logic [7:0] VPWL_IDX_RXBYTE = 8'hf2;
	localparam logic [7:0] VPWL_IDX_CMD = 8'hf3;
	localparam logic [7:0] VPWL_IDX_CTRL = 8'hf4;
	localparam logic [7:0] VPWL_IDX_MASK = 8'hf5;
	localparam logic [7:0] VPWL_IDX_ERR = 8'hf6;
	localparam logic [7:0] VPWL_STATUS_RST = 8'h40;
	localparam logic [7:0] VPWL_CTRL_RST = 8'h00;
	localparam logic [7:0] VPWL_MASK_RST = 8'h00;
	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int VPWL_B_ERR = 7;
	localparam int VPWL_B_SLOT = 6;
	localparam int VPWL_B_RXAV = 5;
	localparam int VPWL_B_ARB = 4;
	localparam int VPWL_B_KIND = 3;
	localparam int VPWL_B_EOD = 2;
	localparam int VPWL_B_EOF = 1;
	localparam int VPWL_B_IDLE = 0;
	localparam int VPWL_B_EN = 0;
	localparam int VPWL_B_DIS = 1;
	localparam int VPWL_B_SLEEP = 2;
	localparam int VPWL_B_FILT = 3;
	localparam int VPWL_B_NEXT = 4;
	localparam int VPWL_E_ABORT = 0;
	localparam int VPWL_E_BIT = 1;
	localparam int VPWL_E_FRAME = 2;
	localparam int VPWL_E_CRC = 3;
	localparam int VPWL_E_BRK = 4;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int VPWL_CLK_MHZ = 25;
	localparam int VPWL_TV3_US = 200;
	localparam int VPWL_TV4_US = 280;
	localparam int VPWL_TV6_US = 300;
	localparam int VPWL_TV3_CYC = VPWL_TV3_US * VPWL_CLK_MHZ;
	localparam int VPWL_TV4_CYC = VPWL_TV4_US * VPWL_CLK_MHZ;
	localparam int VPWL_TV6_CYC = VPWL_TV6_US * VPWL_CLK_MHZ;
	localparam logic [1:0] VPWL_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] VPWL_OP_CANCEL = 3'h0;
	localparam logic [2:0] VPWL_OP_IFR2 = 3'h5;

	typedef enum logic [1:0] {
		VPWL_TX_IDLE = 2'b00,
		VPWL_TX_SEND = 2'b01,
		VPWL_TX_LOCK = 2'b10
	} vpwl_tx_type;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic after_eod;
	} vpwl_rxbyte_type;
endpackage

// [logic/vpwl_top.sv]
// Purpose: Status flags, transmit and receive byte registers of a VPW link
// Assumes: Symbol decoder beside it supplies one-cycle event strobes
// Notes: Status reads return the value latched at the address phase
// Overview of operation
// - Status held at 40h after reset and while the disable bit is set.
// - Enable clear forces all status bits except idle to reset values.
// - Fault summary follows OR of the error bits, cleared by hardware.
// - Each flag except idle set with its mask bit raises the interrupt request.
// - Slot flag clears on command write, sets when the command is accepted.
// - A command write causing the abort error sets the slot flag at once.
// - Lost arbitration frees the slot for current-frame commands only.
// - Bit, frame or checksum errors cancel current-frame command, free slot.
// - A received break cancels everything and frees the slot at once.
// - Byte-available sets on byte transfer, clears on receive register read.
// - Arbitration lost sets on symbol mismatch while sending, except in type 2 responses.
// - After lost arbitration output stays passive until end of data.
// - Lost, data-end and frame-end flags clear on software zero write.
// - Byte kind updates with byte-available: 0 body, 1 response byte.
// - Data-end flag sets after passive Tv3 unless sleep, filter or any error other than abort.
// - Frame-end flag sets after passive Tv4, filtered or sleep frames too.
// - Idle flag sets after passive Tv6, clears on activity or disable.
// - Transmit byte write only stores; shift-in frees the slot.
// - Transmit byte reads return the last written byte.
// - Every received byte goes to the receive register, with no inhibit.
// - DMA transmit request pulses once per slot flag set.
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
module vpwl_top import vpwl_pkg::*; (
	// Clock and reset
	input wire logic CLK_SYS_I,
	input wire logic RST_N_I,
	// AHB-Lite slave
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic [31:0] HRDATA_O,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	// Link pin
	input wire logic BUS_RX_IN_I,
	output logic BUS_TX_OUT_O,
	// Decoder events, one-cycle strobes
	input wire logic RX_BYTE_VALID_I,
	input wire logic [7:0] RX_BYTE_DATA_I,
	input wire logic RX_AFTER_EOD_I,
	input wire logic SYM_MISMATCH_I,
	input wire logic CMD_ACCEPT_I,
	input wire logic TX_SHIFT_LOAD_I,
	input wire logic TX_BIT_I,
	input wire logic [4:0] ERR_SET_I,
	// Requests
	output logic IRQ_O,
	output logic DMA_TX_REQ_O,
	output logic [2:0] CMD_OP_O
);
	// ---------------------------------------------------------------
	// Bus slave
	// ---------------------------------------------------------------
	logic dp_valid_r;
	logic dp_write_r;
	logic [7:0] dp_idx_r;
	logic [7:0] ctrl_r;
	logic [7:0] mask_r;
	logic [7:0] err_r;
	logic [7:0] cmd_r;
	logic [7:0] tx_byte_reg_r;
	logic [7:0] rx_byte_reg_r;
	logic [7:0] status_r;
	logic [7:0] status_nxt;
	logic [7:0] wbyte;
	logic wr_status;
	logic wr_cmd;
	logic wr_tx;
	logic wr_ctrl;
	logic wr_mask;
	logic wr_err;
	logic rd_rx;
	logic link_enable_bit;
	logic link_disable_bit;
	logic cmd_next_frame;
	logic cmd_abort;
	logic cmd_cancel;
	logic in_s1_r;
	logic bus_rx_in;
	logic bus_rx_prev_r;
	logic [31:0] passive_cnt_r;
	logic arb_lost_now;
	logic rx_went_active;
	vpwl_tx_type tx_st_r;
	vpwl_rxbyte_type rxb;

	function automatic logic [7:0] reg_idx(input logic [31:0] a);
		reg_idx = a[9:2];
	endfunction

	function automatic logic hit(input logic [7:0] i, input logic [7:0] t);
		hit = (i == t);
	endfunction

	assign wbyte = HWDATA_I[7:0];
	assign wr_status = dp_valid_r && dp_write_r && hit(dp_idx_r,
		VPWL_IDX_STATUS);
	assign wr_tx = dp_valid_r && dp_write_r && hit(dp_idx_r, VPWL_IDX_TXBYTE);
	assign wr_cmd = dp_valid_r && dp_write_r && hit(dp_idx_r, VPWL_IDX_CMD);
	assign wr_ctrl = dp_valid_r && dp_write_r && hit(dp_idx_r, VPWL_IDX_CTRL);
	assign wr_mask = dp_valid_r && dp_write_r && hit(dp_idx_r, VPWL_IDX_MASK);
	assign wr_err = dp_valid_r && dp_write_r && hit(dp_idx_r, VPWL_IDX_ERR);
	assign rd_rx = dp_valid_r && !dp_write_r && hit(dp_idx_r, VPWL_IDX_RXBYTE);
	assign link_enable_bit = ctrl_r[VPWL_B_EN];
	assign link_disable_bit = ctrl_r[VPWL_B_DIS];
	assign cmd_next_frame = cmd_r[VPWL_B_NEXT];
	// Invalid request: type 2 response not allowed as a command here
	assign cmd_abort = wr_cmd && (wbyte[2:0] == VPWL_OP_IFR2) &&
		!status_r[VPWL_B_IDLE] && RX_AFTER_EOD_I;
	// Next-frame commands survive everything but a break
	assign cmd_cancel = ERR_SET_I[VPWL_E_BRK] || (!cmd_next_frame &&
		(arb_lost_now || ERR_SET_I[VPWL_E_BIT] ||
		ERR_SET_I[VPWL_E_FRAME] || ERR_SET_I[VPWL_E_CRC]));
	assign rxb = '{valid: RX_BYTE_VALID_I, data: RX_BYTE_DATA_I,
		after_eod: RX_AFTER_EOD_I};

	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			dp_valid_r <= 1'b0;
			dp_write_r <= 1'b0;
			dp_idx_r <= 8'h00;
		end else if (HREADY_I) begin
			dp_valid_r <= HSEL_I && HTRANS_I[1];
			dp_write_r <= HWRITE_I;
			dp_idx_r <= reg_idx(HADDR_I);
		end
	end

	// Zero-wait slave; read data registered from the address phase
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			HRDATA_O <= 32'h0000_0000;
			HREADYOUT_O <= 1'b1;
			HRESP_O <= 1'b0;
		end else begin
			HREADYOUT_O <= 1'b1;
			HRESP_O <= 1'b0;
			if (HREADY_I && HSEL_I && HTRANS_I[1] && !HWRITE_I) begin
				unique case (reg_idx(HADDR_I))
				VPWL_IDX_STATUS: HRDATA_O <= {24'h000000, status_nxt};
				VPWL_IDX_TXBYTE: HRDATA_O <= {24'h000000, tx_byte_reg_r};
				VPWL_IDX_RXBYTE: HRDATA_O <= {24'h000000, rx_byte_reg_r};
				VPWL_IDX_CMD: HRDATA_O <= {24'h000000, cmd_r};
				VPWL_IDX_CTRL: HRDATA_O <= {24'h000000, ctrl_r};
				VPWL_IDX_MASK: HRDATA_O <= {24'h000000, mask_r};
				VPWL_IDX_ERR: HRDATA_O <= {24'h000000, err_r};
				default: HRDATA_O <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Software registers
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ctrl_r <= VPWL_CTRL_RST;
			mask_r <= VPWL_MASK_RST;
		end else begin
			if (wr_ctrl)
				ctrl_r <= wbyte;
			if (wr_mask)
				mask_r <= wbyte;
		end
	end

	// Store only; reset content is don't-care but kept defined
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I)
			tx_byte_reg_r <= 8'h00;
		else if (wr_tx)
			tx_byte_reg_r <= wbyte;
	end

	// ---------------------------------------------------------------
	// Command register
	// ---------------------------------------------------------------
	// A fresh write beats a cancel in the same cycle
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I)
			cmd_r <= 8'h00;
		else if (wr_cmd)
			cmd_r <= wbyte;
		else if (cmd_cancel)
			cmd_r <= 8'h00;
	end

	// Error bits: hardware set wins over write-one-to-clear
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I)
			err_r <= 8'h00;
		else if (!link_enable_bit || link_disable_bit)
			err_r <= 8'h00;
		else
			err_r <= ((wr_err ? (err_r & ~wbyte) : err_r) |
				{3'h0, ERR_SET_I}) | {7'h00, cmd_abort};
	end

	// ---------------------------------------------------------------
	// Receive path
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_SYS_I) begin
		if (rxb.valid)
			rx_byte_reg_r <= rxb.data;
	end

	// ---------------------------------------------------------------
	// Input synchroniser and passive timer
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			in_s1_r <= 1'b0;
			bus_rx_in <= 1'b0;
			bus_rx_prev_r <= 1'b0;
		end else begin
			in_s1_r <= BUS_RX_IN_I;
			bus_rx_in <= in_s1_r;
			bus_rx_prev_r <= bus_rx_in;
		end
	end

	assign rx_went_active = bus_rx_in && !bus_rx_prev_r;

	// Runs even while enable is clear, so idle may appear early
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I)
			passive_cnt_r <= 32'h0000_0000;
		else if (bus_rx_in || link_disable_bit)
			passive_cnt_r <= 32'h0000_0000;
		else if (passive_cnt_r <= VPWL_TV6_CYC)
			passive_cnt_r <= passive_cnt_r + 32'h0000_0001;
	end

	// ---------------------------------------------------------------
	// Transmit lock after lost arbitration
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I)
			tx_st_r <= VPWL_TX_IDLE;
		else if (!link_enable_bit || link_disable_bit)
			tx_st_r <= VPWL_TX_IDLE;
		else begin
			unique case (tx_st_r)
			VPWL_TX_IDLE: if (CMD_ACCEPT_I) tx_st_r <= VPWL_TX_SEND;
			VPWL_TX_SEND: begin
				if (SYM_MISMATCH_I && cmd_r[2:0] != VPWL_OP_IFR2)
					tx_st_r <= VPWL_TX_LOCK;
				else if (passive_cnt_r == VPWL_TV3_CYC)
					tx_st_r <= VPWL_TX_IDLE;
			end
			VPWL_TX_LOCK: if (passive_cnt_r == VPWL_TV3_CYC)
				tx_st_r <= VPWL_TX_IDLE;
			default: tx_st_r <= VPWL_TX_IDLE;
			endcase
		end
	end

	assign arb_lost_now = SYM_MISMATCH_I && (tx_st_r == VPWL_TX_SEND) &&
		(cmd_r[2:0] != VPWL_OP_IFR2);

	// ---------------------------------------------------------------
	// Status register
	// ---------------------------------------------------------------
	always_comb begin
		status_nxt = status_r;
		status_nxt[VPWL_B_ERR] = |err_r;
		if (wr_status) begin
			// Only zero writes clear; other bits untouched
			status_nxt[VPWL_B_ARB] = status_r[VPWL_B_ARB] & wbyte[VPWL_B_ARB];
			status_nxt[VPWL_B_EOD] = status_r[VPWL_B_EOD] & wbyte[VPWL_B_EOD];
			status_nxt[VPWL_B_EOF] = status_r[VPWL_B_EOF] & wbyte[VPWL_B_EOF];
		end
		if (rd_rx)
			status_nxt[VPWL_B_RXAV] = 1'b0;
		if (rxb.valid) begin
			status_nxt[VPWL_B_RXAV] = 1'b1;
			status_nxt[VPWL_B_KIND] = rxb.after_eod;
		end
		if (wr_cmd)
			status_nxt[VPWL_B_SLOT] = 1'b0;
		if (CMD_ACCEPT_I || TX_SHIFT_LOAD_I || cmd_abort)
			status_nxt[VPWL_B_SLOT] = 1'b1;
		if (arb_lost_now) begin
			status_nxt[VPWL_B_ARB] = 1'b1;
			if (!cmd_next_frame)
				status_nxt[VPWL_B_SLOT] = 1'b1;
		end
		if ((ERR_SET_I[VPWL_E_BIT] || ERR_SET_I[VPWL_E_FRAME] ||
			ERR_SET_I[VPWL_E_CRC]) && !cmd_next_frame)
			status_nxt[VPWL_B_SLOT] = 1'b1;
		if (ERR_SET_I[VPWL_E_BRK])
			status_nxt[VPWL_B_SLOT] = 1'b1;
		if (passive_cnt_r == VPWL_TV3_CYC && !ctrl_r[VPWL_B_SLEEP] &&
			!ctrl_r[VPWL_B_FILT] && (err_r[4:1] == 4'h0))
			status_nxt[VPWL_B_EOD] = 1'b1;
		if (passive_cnt_r == VPWL_TV4_CYC)
			status_nxt[VPWL_B_EOF] = 1'b1;
		status_nxt[VPWL_B_IDLE] = (status_r[VPWL_B_IDLE] && !rx_went_active)
			|| (!bus_rx_in && passive_cnt_r > VPWL_TV6_CYC);
		if (!link_enable_bit)
			status_nxt[7:1] = VPWL_STATUS_RST[7:1];
		if (link_disable_bit)
			status_nxt = VPWL_STATUS_RST;
	end

	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I)
			status_r <= VPWL_STATUS_RST;
		else
			status_r <= status_nxt;
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			IRQ_O <= 1'b0;
			DMA_TX_REQ_O <= 1'b0;
			BUS_TX_OUT_O <= 1'b0;
			CMD_OP_O <= VPWL_OP_CANCEL;
		end else begin
			IRQ_O <= |(status_nxt[7:1] & mask_r[7:1]);
			DMA_TX_REQ_O <= status_nxt[VPWL_B_SLOT] &&
				!status_r[VPWL_B_SLOT];
			BUS_TX_OUT_O <= (tx_st_r == VPWL_TX_SEND) && TX_BIT_I;
			if (cmd_cancel)
				CMD_OP_O <= VPWL_OP_CANCEL;
			else
				CMD_OP_O <= cmd_r[2:0];
		end
	end
endmodule

// [tb/vpwl_asserts.sv]
// Purpose: Port-level checks of the VPW link status block
// Assumes: Control and mask mirrored here from completed bus writes
// Notes: Event to output delays allow one or two spare cycles
`timescale 1ns/1ps
module vpwl_asserts import vpwl_pkg::*; (
	// Clock, reset and bus
	input wire logic CLK_SYS_I,
	input wire logic RST_N_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	// Link, events and requests
	input wire logic BUS_TX_OUT_O,
	input wire logic SYM_MISMATCH_I,
	input wire logic CMD_ACCEPT_I,
	input wire logic TX_SHIFT_LOAD_I,
	input wire logic RX_BYTE_VALID_I,
	input wire logic [4:0] ERR_SET_I,
	input wire logic IRQ_O,
	input wire logic DMA_TX_REQ_O,
	input wire logic [2:0] CMD_OP_O
);
	// ---------------------------------------------------------------
	// Mirror of control, mask and pending command
	// ---------------------------------------------------------------
	logic wr_r;
	logic [7:0] idx_r;
	logic [7:0] ctrl_r;
	logic [7:0] mask_r;
	logic pend_r;
	logic nxt_r;
	wire logic en = ctrl_r[VPWL_B_EN] & ~ctrl_r[VPWL_B_DIS];
	// Next-frame commands survive frame errors and lost arbitration
	wire logic quiet = !CMD_ACCEPT_I && !TX_SHIFT_LOAD_I && !ERR_SET_I[4]
		&& !ERR_SET_I[0]
		&& (nxt_r || (!SYM_MISMATCH_I && ERR_SET_I[3:1] == 3'h0));
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			wr_r <= 1'b0;
			idx_r <= 8'h00;
		end else begin
			wr_r <= HSEL_I & HREADY_I & HTRANS_I[1] & HWRITE_I;
			idx_r <= HADDR_I[9:2];
		end
	end
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ctrl_r <= VPWL_CTRL_RST;
			mask_r <= VPWL_MASK_RST;
		end else if (wr_r && idx_r == VPWL_IDX_CTRL)
			ctrl_r <= HWDATA_I[7:0];
		else if (wr_r && idx_r == VPWL_IDX_MASK)
			mask_r <= HWDATA_I[7:0];
	end
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			pend_r <= 1'b0;
			nxt_r <= 1'b0;
		end else if (wr_r && idx_r == VPWL_IDX_CMD && en) begin
			pend_r <= 1'b1;
			nxt_r <= HWDATA_I[VPWL_B_NEXT];
		end else if (DMA_TX_REQ_O)
			pend_r <= 1'b0;
	end
	default clocking cb @(posedge CLK_SYS_I);
	endclocking
	default disable iff (!RST_N_I);
	a_dma_single: assert property (
		DMA_TX_REQ_O |=> !DMA_TX_REQ_O)
		else $error("DMA request longer than one cycle");
	a_accept_frees: assert property (
		pend_r && en && (CMD_ACCEPT_I || TX_SHIFT_LOAD_I)
		|-> ##[1:3] DMA_TX_REQ_O)
		else $error("Accepted command did not free the slot");
	a_cmd_holds: assert property (
		(pend_r && en && quiet) [*3] |-> !DMA_TX_REQ_O)
		else $error("Slot freed with no cause");
	a_err_frees: assert property (
		pend_r && en && (ERR_SET_I[4] || (!nxt_r && ERR_SET_I[3:1] != 0))
		|-> ##[1:3] DMA_TX_REQ_O)
		else $error("Frame error did not free the slot");
	a_arb_frees: assert property (
		pend_r && en && !nxt_r && SYM_MISMATCH_I
		&& CMD_OP_O != VPWL_OP_IFR2 |-> ##[1:3] DMA_TX_REQ_O)
		else $error("Lost arbitration did not free the slot");
	a_arb_passive: assert property (
		SYM_MISMATCH_I && en |-> ##2 !BUS_TX_OUT_O [*3])
		else $error("Output active after lost arbitration");
	a_rx_irq: assert property (
		RX_BYTE_VALID_I && en && mask_r[VPWL_B_RXAV] |-> ##[1:2] IRQ_O)
		else $error("Received byte raised no request");
	a_off_quiet: assert property (
		(!en && !mask_r[VPWL_B_SLOT]) [*3] |-> !IRQ_O)
		else $error("Request while link not enabled");
	c_accept: cover property (pend_r && CMD_ACCEPT_I);
	c_arb: cover property (pend_r && SYM_MISMATCH_I);
	c_rx_irq: cover property (RX_BYTE_VALID_I && IRQ_O);
endmodule
bind vpwl_top vpwl_asserts i_chk (.CLK_SYS_I, .RST_N_I, .HSEL_I, .HADDR_I,
	.HTRANS_I, .HWRITE_I, .HWDATA_I, .HREADY_I, .BUS_TX_OUT_O,
	.SYM_MISMATCH_I, .CMD_ACCEPT_I, .TX_SHIFT_LOAD_I, .RX_BYTE_VALID_I,
	.ERR_SET_I, .IRQ_O, .DMA_TX_REQ_O, .CMD_OP_O);

// [tb/vpwl_node.sv]
// Purpose: Far-side node on the VPW link
// Assumes: Shared wire, active level dominant
// Notes: Own output reaches the input as on the real wire
`timescale 1ns/1ps
module vpwl_node (
	// Link
	input wire logic tx_i,
	input wire logic act_i,
	output logic rx_o
);
	assign rx_o = tx_i | act_i;
endmodule

// [tb/tb_top.sv]
// Purpose: Self-checking bench for the VPW link status block
// Assumes: Zero-wait bus slave, decoder events driven here
// Notes: Symbol times at package values, run near 8k cycles
`timescale 1ns/1ps
`define CHK(a, e) begin \
	n_tests++; \
	if ((a) !== (e)) begin \
		bad_count++; \
		$display("BAD %0t mismatch got %h", $time, (a)); \
	end \
end
module tb_top import vpwl_pkg::*;;
	// ---------------------------------------------------------------
	// Stimulus, tasks and tests
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [4:0] f;
		logic [7:0] d;
		logic [4:0] e;
		logic [7:0] st;
	} vpwl_row_type;
	vpwl_row_type rows [7] = '{'{5'h03, 8'h3c, 5'h00, 8'h68},
		'{5'h01, 8'ha5, 5'h00, 8'h60}, '{5'h00, 8'h00, 5'h01, 8'hc0},
		'{5'h00, 8'h00, 5'h02, 8'hc0}, '{5'h00, 8'h00, 5'h04, 8'hc0},
		'{5'h00, 8'h00, 5'h08, 8'hc0}, '{5'h00, 8'h00, 5'h10, 8'hc0}};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic rxv = 1'b0, aft = 1'b0, mm = 1'b0, acc = 1'b0, ld = 1'b0;
	logic txb = 1'b0, act = 1'b1;
	logic [7:0] rxd = 8'h00;
	logic [4:0] err = 5'h00;
	logic [31:0] hrdata, rd;
	logic hrdy, hresp, rx_in, tx_out, irq, dma;
	logic [2:0] op;
	int bad_count = 0, n_tests = 0, dma_n = 0, i;
	always #20 clk = ~clk;
	always @(posedge clk) if (dma === 1'b1) dma_n++;
	vpwl_top i_dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel),
		.HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
		.HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hrdy),
		.HRDATA_O(hrdata), .HREADYOUT_O(hrdy), .HRESP_O(hresp),
		.BUS_RX_IN_I(rx_in), .BUS_TX_OUT_O(tx_out), .RX_BYTE_VALID_I(rxv),
		.RX_BYTE_DATA_I(rxd), .RX_AFTER_EOD_I(aft), .SYM_MISMATCH_I(mm),
		.CMD_ACCEPT_I(acc), .TX_SHIFT_LOAD_I(ld), .TX_BIT_I(txb),
		.ERR_SET_I(err), .IRQ_O(irq), .DMA_TX_REQ_O(dma), .CMD_OP_O(op));
	vpwl_node i_node (.tx_i(tx_out), .act_i(act), .rx_o(rx_in));
	task automatic wrap_up();
		$display("Counts: %0d checks, %0d bad", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic rdy();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hrdy !== 1'b1 && n < 16);
		if (hrdy !== 1'b1) begin
			bad_count++;
			$display("BAD %0t bus timeout", $time);
			wrap_up();
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] ix,
		input logic [7:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= VPWL_HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {22'h0, ix, 2'b00};
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		rdy();
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] ix, input logic [7:0] d);
		xfer(1'b1, ix, d);
	endtask
	task automatic chk(input logic [7:0] ix, input logic [7:0] e);
		xfer(1'b0, ix, 8'h00);
		`CHK(rd[7:0], e)
	endtask
	// Strobes in f: mismatch, shift load, accept, after data end, byte
	task automatic ev(input logic [4:0] f, input logic [7:0] d,
		input logic [4:0] e);
		@(posedge clk);
		{mm, ld, acc, aft, rxv} <= f;
		rxd <= d;
		err <= e;
		@(posedge clk);
		{mm, ld, acc, aft, rxv} <= 5'h00;
		err <= 5'h00;
	endtask
	task automatic tidy();
		wr(VPWL_IDX_ERR, 8'h1f);
		wr(VPWL_IDX_STATUS, 8'h00);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		chk(VPWL_IDX_STATUS, VPWL_STATUS_RST);
		`CHK(hresp, 1'b0)
		ev(5'h01, 8'h11, 5'h00);
		chk(VPWL_IDX_STATUS, VPWL_STATUS_RST);
		$display("Test reset done");
		// Idle timing first, before any error can inhibit data end
		wr(VPWL_IDX_CTRL, 8'h01);
		act <= 1'b0;
		repeat (VPWL_TV3_CYC + 60) @(posedge clk);
		chk(VPWL_IDX_STATUS, 8'h44);
		repeat (VPWL_TV4_CYC - VPWL_TV3_CYC) @(posedge clk);
		chk(VPWL_IDX_STATUS, 8'h46);
		repeat (VPWL_TV6_CYC - VPWL_TV4_CYC) @(posedge clk);
		chk(VPWL_IDX_STATUS, 8'h47);
		act <= 1'b1;
		wr(VPWL_IDX_STATUS, 8'h00);
		chk(VPWL_IDX_STATUS, 8'h40);
		$display("Test idle done");
		for (i = 0; i < 7; i++) begin
			ev(rows[i].f, rows[i].d, rows[i].e);
			chk(VPWL_IDX_STATUS, rows[i].st);
			if (rows[i].f[0])
				chk(VPWL_IDX_RXBYTE, rows[i].d);
			tidy();
			// Byte kind stays until the next received byte
			chk(VPWL_IDX_STATUS, 8'h40 | (rows[i].st & 8'h08));
		end
		$display("Test table done");
		txb <= 1'b1;
		wr(VPWL_IDX_TXBYTE, 8'h5a);
		chk(VPWL_IDX_TXBYTE, 8'h5a);
		chk(VPWL_IDX_STATUS, 8'h40);
		wr(VPWL_IDX_CMD, 8'h02);
		chk(VPWL_IDX_STATUS, 8'h00);
		`CHK(op, 3'h2)
		wr(VPWL_IDX_TXBYTE, 8'h96);
		chk(VPWL_IDX_TXBYTE, 8'h96);
		i = dma_n;
		ev(5'h04, 8'h00, 5'h00);
		chk(VPWL_IDX_STATUS, 8'h40);
		`CHK(dma_n, i + 1)
		wr(VPWL_IDX_CMD, 8'h02);
		ev(5'h08, 8'h00, 5'h00);
		chk(VPWL_IDX_STATUS, 8'h40);
		wr(VPWL_IDX_CMD, 8'h02);
		ev(5'h10, 8'h00, 5'h00);
		chk(VPWL_IDX_STATUS, 8'h50);
		`CHK(tx_out, 1'b0)
		`CHK(op, VPWL_OP_CANCEL)
		wr(VPWL_IDX_STATUS, 8'h16);
		chk(VPWL_IDX_STATUS, 8'h50);
		wr(VPWL_IDX_STATUS, 8'h00);
		chk(VPWL_IDX_STATUS, 8'h40);
		txb <= 1'b0;
		$display("Test tx done");
		wr(VPWL_IDX_CMD, 8'h02);
		ev(5'h00, 8'h00, 5'h08);
		chk(VPWL_IDX_STATUS, 8'hc0);
		`CHK(op, VPWL_OP_CANCEL)
		wr(VPWL_IDX_CMD, 8'h12);
		ev(5'h00, 8'h00, 5'h02);
		chk(VPWL_IDX_STATUS, 8'h80);
		`CHK(op, 3'h2)
		ev(5'h00, 8'h00, 5'h10);
		chk(VPWL_IDX_STATUS, 8'hc0);
		`CHK(op, VPWL_OP_CANCEL)
		tidy();
		$display("Test errors done");
		wr(VPWL_IDX_MASK, 8'h20);
		ev(5'h01, 8'h77, 5'h00);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b1)
		chk(VPWL_IDX_RXBYTE, 8'h77);
		chk(VPWL_IDX_RXBYTE, 8'h77);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		ev(5'h01, 8'h78, 5'h00);
		aft <= 1'b1;
		wr(VPWL_IDX_CMD, {5'h00, VPWL_OP_IFR2});
		aft <= 1'b0;
		chk(VPWL_IDX_STATUS, 8'he0);
		wr(VPWL_IDX_CTRL, 8'h03);
		chk(VPWL_IDX_STATUS, VPWL_STATUS_RST);
		`CHK(irq, 1'b0)
		$display("Test irq done");
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		chk(VPWL_IDX_CTRL, VPWL_CTRL_RST);
		chk(VPWL_IDX_STATUS, VPWL_STATUS_RST);
		`CHK(irq, 1'b0)
		$display("Test second reset done");
		wrap_up();
	end
endmodule
